// File: core/age_relay.sv
`timescale 1ns/1ns
`default_nettype none
module age_relay (
	input wire logic [15:0] rxAge,
	input wire logic isRoot,
	output logic [15:0] txAge
);
	// root sends age zero, others add one step
	assign txAge = isRoot ? 16'h0000 : 16'(rxAge + stp_mgmt_pkg::MSG_AGE_INCR);
endmodule // age_relay
`default_nettype wire

// File: core/port_id_unit.sv
`timescale 1ns/1ns
`default_nettype none
module port_id_unit (
	input wire logic [7:0] prio,
	input wire logic [7:0] portNum,
	input wire logic [15:0] candidate,
	input wire logic [15:0] recorded,
	output logic [15:0] newId,
	output logic isHigher
);
	// priority in the upper byte, port number below
	assign newId = {prio, portNum};
	assign isHigher = candidate < recorded;
endmodule // port_id_unit
`default_nettype wire

// File: core/stp_mgmt_pkg.sv
`default_nettype none
package stp_mgmt_pkg;
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_ARG = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_BRID_LO = 8'h0C;
	localparam logic [7:0] OFF_BRID_HI = 8'h10;
	localparam logic [7:0] OFF_ROOT_PORT = 8'h14;
	localparam logic [7:0] OFF_DROOT_LO = 8'h18;
	localparam logic [7:0] OFF_DROOT_HI = 8'h1C;
	localparam logic [7:0] OFF_ROOT_COST = 8'h20;
	localparam logic [7:0] OFF_PORT_SEL = 8'h24;
	localparam logic [7:0] OFF_PORT_ID = 8'h28;
	localparam logic [7:0] OFF_PATH_COST = 8'h2C;
	localparam logic [7:0] OFF_DES_PORT = 8'h30;
	localparam logic [7:0] OFF_PORT_CTRL = 8'h34;
	localparam logic [7:0] OFF_DES_BR_LO = 8'h38;
	localparam logic [7:0] OFF_DES_BR_HI = 8'h3C;
	localparam logic [7:0] OFF_RX_AGE = 8'h40;
	localparam logic [7:0] OFF_TX_AGE = 8'h44;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_PORT_LSB = 8;
	localparam int CTRL_STATE_LSB = 0;
	localparam int CTRL_CDE_BIT = 4;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_ROOT_BIT = 1;
	// arbitrary bridge identifier value
	localparam logic [63:0] BRIDGE_ID_RST = 64'h8000_0000_0000_0001;
	localparam logic [7:0] PORT_PRIO_RST = 8'h80;
	localparam logic [31:0] DEFAULT_PATH_COST = 32'h0000_000A;
	localparam logic [15:0] MSG_AGE_INCR = 16'h0001;
	localparam logic [7:0] NO_PORT = 8'h00;
	localparam logic [7:0] FIRST_PORT = 8'h01;

	typedef enum logic [2:0] {
		ST_DISABLED,
		ST_LISTENING,
		ST_LEARNING,
		ST_FORWARDING,
		ST_BLOCKING
	} port_state_t;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_SET_PRIO,
		OP_SET_COST,
		OP_CD_ENABLE,
		OP_CD_DISABLE
	} op_t;

	typedef struct packed {
		logic [15:0] portId;
		logic [31:0] pathCost;
		logic [63:0] desigBridge;
		logic [15:0] desigPort;
		port_state_t state;
		logic cdEnable;
	} port_rec_t;

	typedef struct packed {
		logic [7:0] msgType;
		logic [63:0] rootId;
		logic [31:0] rootPathCost;
		logic [63:0] bridgeId;
		logic [15:0] portId;
		logic [15:0] messageAge;
		logic [15:0] maxAge;
		logic [15:0] helloTime;
		logic [15:0] forwardDelay;
		logic tcAck;
		logic topoChange;
	} config_msg_t;
endpackage
`default_nettype wire

// File: core/stp_port_mgmt.sv
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module stp_port_mgmt #(
	parameter int NUM_PORTS = 2
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic cfgUpdateReq,
	output logic stateSelReq,
	output logic [7:0] procPort
);
	typedef enum logic [2:0] {
		S_IDLE,
		S_CALC,
		S_DESIG,
		S_STORE,
		S_BECOME,
		S_CFGUPD,
		S_SELECT
	} seq_t;

	typedef struct packed {
		stp_mgmt_pkg::port_rec_t [NUM_PORTS:1] ports;
		logic [63:0] bridgeId;
		logic [63:0] desigRoot;
		logic [31:0] rootCost;
		logic [7:0] rootPort;
		logic [7:0] selPort;
		logic [31:0] arg;
		logic [15:0] rxAge;
		seq_t seq;
		stp_mgmt_pkg::op_t op;
		logic [7:0] cmdPort;
		logic [15:0] newId;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic cfgUpd;
		logic stateSel;
	} state_t;

	state_t cur_ff;
	state_t nxt_cur;
	logic [15:0] calcId;
	logic newIsHigher;
	logic [15:0] txAge;
	logic isRoot;
	logic [7:0] cmdPortW;
	logic [2:0] cmdOpW;
	logic cmdPortOk;
	logic selOk;
	logic cmdOpOk;
	logic cmdLegal;
	logic cmdValid;
	logic seqBusy;
	logic [7:0] rootPortRd;
	logic [NUM_PORTS:1] segDesig;
	logic [NUM_PORTS:1] ownDesig;
	logic hit;
	logic [31:0] rdata;
	logic setup;
	logic access;
	stp_mgmt_pkg::port_rec_t cmdRec;
	stp_mgmt_pkg::port_rec_t selRec;

	assign isRoot = cur_ff.desigRoot == cur_ff.bridgeId;
	assign cmdPortW = pwdata[stp_mgmt_pkg::CMD_PORT_LSB +: 8];
	assign cmdOpW = pwdata[stp_mgmt_pkg::CMD_OP_LSB +: 3];
	assign cmdPortOk = (cmdPortW >= stp_mgmt_pkg::FIRST_PORT) && (cmdPortW <= 8'(NUM_PORTS));
	assign selOk = (cur_ff.selPort >= stp_mgmt_pkg::FIRST_PORT) &&
		(cur_ff.selPort <= 8'(NUM_PORTS));
	assign seqBusy = cur_ff.seq != S_IDLE;
	assign cmdOpOk = (cmdOpW != 3'(stp_mgmt_pkg::OP_NONE)) &&
		(cmdOpW <= 3'(stp_mgmt_pkg::OP_CD_DISABLE));
	assign cmdLegal = cmdPortOk && !seqBusy && cmdOpOk;
	// port zero after reset has no record
	assign cmdValid = (cur_ff.cmdPort >= stp_mgmt_pkg::FIRST_PORT) &&
		(cur_ff.cmdPort <= 8'(NUM_PORTS));
	assign cmdRec = cmdValid ? cur_ff.ports[cur_ff.cmdPort] : '0;
	assign rootPortRd = isRoot ? stp_mgmt_pkg::NO_PORT : cur_ff.rootPort;
	assign selRec = selOk ? cur_ff.ports[cur_ff.selPort] : '0;
	// apb phases
	assign setup = psel && !penable;
	assign access = psel && penable && cur_ff.pready;

	port_id_unit u_portId (
		.prio(cur_ff.arg[7:0]),
		.portNum(cur_ff.cmdPort),
		.candidate(cur_ff.newId),
		.recorded(cmdRec.desigPort),
		.newId(calcId),
		.isHigher(newIsHigher)
	);

	age_relay u_ageRelay (
		.rxAge(cur_ff.rxAge),
		.isRoot(isRoot),
		.txAge(txAge)
	);

	// segment role of each port
	for (genvar g = 1; g <= NUM_PORTS; g++) begin : g_role
		assign ownDesig[g] = cur_ff.ports[g].desigBridge == cur_ff.bridgeId;
		assign segDesig[g] = ownDesig[g] &&
			(cur_ff.ports[g].desigPort == cur_ff.ports[g].portId);
	end

	// read decode
	always_comb begin
		hit = 1'b1;
		rdata = 32'h0000_0000;
		if (paddr == stp_mgmt_pkg::OFF_CMD) begin
			rdata = {16'h0000, cur_ff.cmdPort, 5'h00, cur_ff.op};
		end else if (paddr == stp_mgmt_pkg::OFF_ARG) begin
			rdata = cur_ff.arg;
		end else if (paddr == stp_mgmt_pkg::OFF_STATUS) begin
			rdata[stp_mgmt_pkg::STATUS_BUSY_BIT] = seqBusy;
			rdata[stp_mgmt_pkg::STATUS_ROOT_BIT] = isRoot;
		end else if (paddr == stp_mgmt_pkg::OFF_BRID_LO) begin
			rdata = cur_ff.bridgeId[31:0];
		end else if (paddr == stp_mgmt_pkg::OFF_BRID_HI) begin
			rdata = cur_ff.bridgeId[63:32];
		end else if (paddr == stp_mgmt_pkg::OFF_ROOT_PORT) begin
			rdata = {24'h00_0000, rootPortRd};
		end else if (paddr == stp_mgmt_pkg::OFF_DROOT_LO) begin
			rdata = cur_ff.desigRoot[31:0];
		end else if (paddr == stp_mgmt_pkg::OFF_DROOT_HI) begin
			rdata = cur_ff.desigRoot[63:32];
		end else if (paddr == stp_mgmt_pkg::OFF_ROOT_COST) begin
			rdata = cur_ff.rootCost;
		end else if (paddr == stp_mgmt_pkg::OFF_PORT_SEL) begin
			rdata = {24'h00_0000, cur_ff.selPort};
		end else if (paddr == stp_mgmt_pkg::OFF_PORT_ID) begin
			rdata = {16'h0000, selRec.portId};
		end else if (paddr == stp_mgmt_pkg::OFF_PATH_COST) begin
			rdata = selRec.pathCost;
		end else if (paddr == stp_mgmt_pkg::OFF_DES_PORT) begin
			rdata = {16'h0000, selRec.desigPort};
		end else if (paddr == stp_mgmt_pkg::OFF_PORT_CTRL) begin
			rdata[stp_mgmt_pkg::CTRL_STATE_LSB +: 3] = selRec.state;
			rdata[stp_mgmt_pkg::CTRL_CDE_BIT] = selRec.cdEnable;
		end else if (paddr == stp_mgmt_pkg::OFF_DES_BR_LO) begin
			rdata = selRec.desigBridge[31:0];
		end else if (paddr == stp_mgmt_pkg::OFF_DES_BR_HI) begin
			rdata = selRec.desigBridge[63:32];
		end else if (paddr == stp_mgmt_pkg::OFF_RX_AGE) begin
			rdata = {16'h0000, cur_ff.rxAge};
		end else if (paddr == stp_mgmt_pkg::OFF_TX_AGE) begin
			rdata = {16'h0000, txAge};
		end else begin
			hit = 1'b0;
		end
	end

	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.pready = 1'b0;
		nxt_cur.pslverr = 1'b0;
		nxt_cur.cfgUpd = 1'b0;
		nxt_cur.stateSel = 1'b0;
		// apb answer prepared in setup, shown in the first access cycle
		if (setup) begin
			nxt_cur.pready = 1'b1;
			nxt_cur.prdata = pwrite ? 32'h0000_0000 : rdata;
			nxt_cur.pslverr = !hit || (pwrite && (paddr == stp_mgmt_pkg::OFF_CMD) && !cmdLegal);
		end
		// sequencer
		case (cur_ff.seq)
			S_IDLE: begin
			end
			S_CALC: begin
				nxt_cur.newId = calcId;
				nxt_cur.seq = S_DESIG;
			end
			S_DESIG: begin
				if (segDesig[cur_ff.cmdPort]) begin
					nxt_cur.ports[cur_ff.cmdPort].desigPort = cur_ff.newId;
				end
				nxt_cur.seq = S_STORE;
			end
			S_STORE: begin
				nxt_cur.ports[cur_ff.cmdPort].portId = cur_ff.newId;
				if (ownDesig[cur_ff.cmdPort] && newIsHigher) begin
					nxt_cur.seq = S_BECOME;
				end else begin
					nxt_cur.seq = S_IDLE;
				end
			end
			S_BECOME: begin
				nxt_cur.ports[cur_ff.cmdPort].desigBridge = cur_ff.bridgeId;
				nxt_cur.ports[cur_ff.cmdPort].desigPort = cmdRec.portId;
				nxt_cur.stateSel = 1'b1;
				nxt_cur.seq = S_SELECT;
			end
			S_CFGUPD: begin
				nxt_cur.stateSel = 1'b1;
				nxt_cur.seq = S_SELECT;
			end
			S_SELECT: begin
				nxt_cur.seq = S_IDLE;
			end
			default: begin
				nxt_cur.seq = S_IDLE;
			end
		endcase
		// register writes take effect at the completing access edge
		if (access && pwrite) begin
			if (paddr == stp_mgmt_pkg::OFF_CMD) begin
				// refused in setup stays refused at access
				if (cmdLegal && !cur_ff.pslverr) begin
					nxt_cur.op = stp_mgmt_pkg::op_t'(cmdOpW);
					nxt_cur.cmdPort = cmdPortW;
					if (cmdOpW == 3'(stp_mgmt_pkg::OP_SET_PRIO)) begin
						nxt_cur.seq = S_CALC;
					end else if (cmdOpW == 3'(stp_mgmt_pkg::OP_SET_COST)) begin
						nxt_cur.ports[cmdPortW].pathCost = cur_ff.arg;
						nxt_cur.cfgUpd = 1'b1;
						nxt_cur.seq = S_CFGUPD;
					end else if (cmdOpW == 3'(stp_mgmt_pkg::OP_CD_ENABLE)) begin
						nxt_cur.ports[cmdPortW].cdEnable = 1'b1;
					end else begin
						nxt_cur.ports[cmdPortW].cdEnable = 1'b0;
					end
				end
			end else if (paddr == stp_mgmt_pkg::OFF_ARG) begin
				nxt_cur.arg = pwdata;
			end else if (paddr == stp_mgmt_pkg::OFF_BRID_LO) begin
				nxt_cur.bridgeId[31:0] = pwdata;
			end else if (paddr == stp_mgmt_pkg::OFF_BRID_HI) begin
				nxt_cur.bridgeId[63:32] = pwdata;
			end else if (paddr == stp_mgmt_pkg::OFF_ROOT_PORT) begin
				nxt_cur.rootPort = pwdata[7:0];
			end else if (paddr == stp_mgmt_pkg::OFF_DROOT_LO) begin
				nxt_cur.desigRoot[31:0] = pwdata;
			end else if (paddr == stp_mgmt_pkg::OFF_DROOT_HI) begin
				nxt_cur.desigRoot[63:32] = pwdata;
			end else if (paddr == stp_mgmt_pkg::OFF_ROOT_COST) begin
				nxt_cur.rootCost = pwdata;
			end else if (paddr == stp_mgmt_pkg::OFF_PORT_SEL) begin
				nxt_cur.selPort = pwdata[7:0];
			end else if (paddr == stp_mgmt_pkg::OFF_RX_AGE) begin
				nxt_cur.rxAge = pwdata[15:0];
			end else if (selOk && !seqBusy) begin
				// per-port fields hold still while a command runs
				if (paddr == stp_mgmt_pkg::OFF_DES_PORT) begin
					nxt_cur.ports[cur_ff.selPort].desigPort = pwdata[15:0];
				end else if (paddr == stp_mgmt_pkg::OFF_DES_BR_LO) begin
					nxt_cur.ports[cur_ff.selPort].desigBridge[31:0] = pwdata;
				end else if (paddr == stp_mgmt_pkg::OFF_DES_BR_HI) begin
					nxt_cur.ports[cur_ff.selPort].desigBridge[63:32] = pwdata;
				end else if (paddr == stp_mgmt_pkg::OFF_PORT_CTRL) begin
					// out-of-range state codes are ignored
					if (pwdata[stp_mgmt_pkg::CTRL_STATE_LSB +: 3] <= 3'(stp_mgmt_pkg::ST_BLOCKING)) begin
						nxt_cur.ports[cur_ff.selPort].state =
							stp_mgmt_pkg::port_state_t'(pwdata[stp_mgmt_pkg::CTRL_STATE_LSB +: 3]);
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			// every port blocking, detecting changes and designated for its segment
			cur_ff <= '0;
			for (int i = 1; i <= NUM_PORTS; i++) begin
				cur_ff.ports[i].portId <= {stp_mgmt_pkg::PORT_PRIO_RST, 8'(i)};
				cur_ff.ports[i].pathCost <= stp_mgmt_pkg::DEFAULT_PATH_COST;
				cur_ff.ports[i].desigBridge <= stp_mgmt_pkg::BRIDGE_ID_RST;
				cur_ff.ports[i].desigPort <= {stp_mgmt_pkg::PORT_PRIO_RST, 8'(i)};
				cur_ff.ports[i].state <= stp_mgmt_pkg::ST_BLOCKING;
				cur_ff.ports[i].cdEnable <= 1'b1;
			end
			cur_ff.bridgeId <= stp_mgmt_pkg::BRIDGE_ID_RST;
			cur_ff.desigRoot <= stp_mgmt_pkg::BRIDGE_ID_RST;
			cur_ff.rootPort <= stp_mgmt_pkg::NO_PORT;
			cur_ff.selPort <= stp_mgmt_pkg::FIRST_PORT;
			cur_ff.seq <= S_IDLE;
			cur_ff.op <= stp_mgmt_pkg::OP_NONE;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign prdata = cur_ff.prdata;
	assign pready = cur_ff.pready;
	assign pslverr = cur_ff.pslverr;
	// one-cycle requests to the procedures outside
	assign cfgUpdateReq = cur_ff.cfgUpd;
	assign stateSelReq = cur_ff.stateSel;
	assign procPort = cur_ff.cmdPort;
endmodule // stp_port_mgmt
`default_nettype wire

// File: test/stp_far_side.sv
`timescale 1ns/1ns
`default_nettype none
module stp_far_side (
	input wire logic sys_clk,
	input wire logic cfgUpdateReq,
	input wire logic stateSelReq
);
	// counts procedure runs requested
	int cfgCnt = 0;
	int selCnt = 0;
	always @(posedge sys_clk) begin
		cfgCnt <= cfgCnt + int'(cfgUpdateReq);
		selCnt <= selCnt + int'(stateSelReq);
	end
endmodule // stp_far_side
`default_nettype wire

// File: test/stp_port_mgmt_chk.sv
`timescale 1ns/1ns
`default_nettype none
module stp_port_mgmt_chk #(
	parameter int NUM_PORTS = 2
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cfgUpdateReq,
	input wire logic stateSelReq,
	input wire logic [7:0] procPort
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	wire logic done = psel && penable && pready;
	sequence s_cmd(logic [2:0] op);
		done && pwrite && paddr == 8'h00 && pwdata[2:0] == op && !pslverr;
	endsequence
	sequence s_cost_run;
		cfgUpdateReq ##1 stateSelReq;
	endsequence
	a_cost_start: assert property (s_cmd(3'h2) |=> s_cost_run)
		else $error("cost command without update");
	a_cfg_then_sel: assert property (cfgUpdateReq |=> stateSelReq)
		else $error("update not followed by selection");
	a_cfg_single: assert property (cfgUpdateReq |=> !cfgUpdateReq)
		else $error("update pulse too long");
	a_sel_single: assert property (stateSelReq |=> !stateSelReq)
		else $error("selection pulse too long");
	a_prio_quiet: assert property (s_cmd(3'h1) |=> !cfgUpdateReq [*5])
		else $error("priority change ran update");
	a_cmd_port: assert property (done && pwrite && paddr == 8'h00 && !pslverr
		|=> procPort == $past(pwdata[15:8])) else $error("port not latched");
	a_port_zero: assert property (done && pwrite && paddr == 8'h00
		&& pwdata[15:8] == 8'h00 |-> pslverr) else $error("port zero accepted");
	a_sel_port: assert property (stateSelReq |-> procPort >= 1 && procPort <= NUM_PORTS)
		else $error("selection for bad port");
	a_state_code: assert property (done && !pwrite && paddr == 8'h34
		|-> prdata[2:0] <= 3'h4) else $error("bad state code");
endmodule // stp_port_mgmt_chk
bind stp_port_mgmt stp_port_mgmt_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (
	.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .cfgUpdateReq(cfgUpdateReq),
	.stateSelReq(stateSelReq), .procPort(procPort)
);
`default_nettype wire

// File: test/stp_port_mgmt_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module stp_port_mgmt_tb_top;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cfgUpdateReq;
	logic stateSelReq;
	logic [7:0] procPort;
	logic [31:0] rd;
	logic er;
	logic [7:0] pr;
	logic [15:0] age;
	logic [31:0] cost;
	logic [31:0] bad [4] = '{32'h0000_0001, 32'h0000_0301, 32'h0000_0105, 32'h0000_0100};
	int error_cnt = 0;
	int n_compared = 0;
	int seed = 32'hb8bc;
	int c0;
	int s0;
	always #25 sys_clk = ~sys_clk;
	stp_port_mgmt #(.NUM_PORTS(2)) DUT (
		.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cfgUpdateReq(cfgUpdateReq),
		.stateSelReq(stateSelReq), .procPort(procPort)
	);
	stp_far_side far (.sys_clk(sys_clk), .cfgUpdateReq(cfgUpdateReq), .stateSelReq(stateSelReq));
	function automatic logic [31:0] pid(input logic [7:0] p, input logic [7:0] n);
		return {16'h0000, p, n};
	endfunction
	function automatic logic [31:0] tx_age(input logic root, input logic [15:0] a);
		return root ? 32'h0000_0000 : {16'h0000, a + 16'h0001};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask
	task automatic cmd(input logic [2:0] op, input logic [7:0] port, input logic [31:0] arg);
		apb(1'b1, 8'h04, arg);
		apb(1'b1, 8'h00, {16'h0000, port, 5'h00, op});
		repeat (8) @(posedge sys_clk);
	endtask
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#2_000_000;
		error_cnt++;
		close_out();
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		rdchk(8'h28, pid(8'h80, 8'h01));
		rdchk(8'h14, 32'h0000_0000);
		rdchk(8'h34, 32'h0000_0014);
		pr = 8'($random(seed));
		cmd(3'h1, 8'h01, {24'h00_0000, pr});
		rdchk(8'h28, pid(pr, 8'h01));
		rdchk(8'h30, pid(pr, 8'h01));
		for (int i = 0; i < 4; i++) begin
			pr = 8'($random(seed));
			apb(1'b1, 8'h30, (i % 2) ? 32'h0000_FFFF : 32'h0000_0000);
			s0 = far.selCnt;
			cmd(3'h1, 8'h01, {24'h00_0000, pr});
			chk(far.selCnt - s0, i % 2);
			rdchk(8'h30, (i % 2) ? pid(pr, 8'h01) : 32'h0000_0000);
		end
		cost = $random(seed);
		c0 = far.cfgCnt;
		s0 = far.selCnt;
		cmd(3'h2, 8'h02, cost);
		chk(far.cfgCnt - c0, 1);
		chk(far.selCnt - s0, 1);
		chk({24'h00_0000, procPort}, 32'h0000_0002);
		apb(1'b1, 8'h24, 32'h0000_0002);
		rdchk(8'h2C, cost);
		cmd(3'h4, 8'h02, 32'h0000_0000);
		rdchk(8'h34, 32'h0000_0004);
		cmd(3'h3, 8'h02, 32'h0000_0000);
		rdchk(8'h34, 32'h0000_0014);
		for (int s = 0; s < 6; s++) begin
			apb(1'b1, 8'h34, s);
			rdchk(8'h34, 32'h0000_0010 | ((s < 5) ? s : 4));
		end
		foreach (bad[i]) begin
			apb(1'b1, 8'h00, bad[i]);
			chk(32'(er), 32'h0000_0001);
		end
		apb(1'b0, 8'h48, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk(32'(er), 32'h0000_0001);
		age = 16'($random(seed));
		apb(1'b1, 8'h40, {16'h0000, age});
		rdchk(8'h44, tx_age(1'b1, age));
		apb(1'b1, 8'h14, 32'h0000_0001);
		rdchk(8'h14, 32'h0000_0000);
		apb(1'b1, 8'h18, 32'h0000_0002);
		rdchk(8'h08, 32'h0000_0000);
		rdchk(8'h14, 32'h0000_0001);
		rdchk(8'h44, tx_age(1'b0, age));
		apb(1'b1, 8'h40, 32'h0000_FFFF);
		rdchk(8'h44, tx_age(1'b0, 16'hFFFF));
		close_out();
	end
endmodule // stp_port_mgmt_tb_top
`default_nettype wire
